// ===== dv/ccu_analog_model.sv
// Behavioural oscillator and PLL answering the power enables of the clock unit.
`timescale 1ns/10ps

module ccu_analog_model #(
   parameter int LOCK_CYC = 8
) (
   // Clock
   input  wire logic core_clk_i,
   // Power enables from the unit
   input  wire logic osc_en_i,
   input  wire logic pll_en_i,
   // Fault injection from the bench
   input  wire logic lose_osc_i,
   input  wire logic lose_lock_i,
   // Status back to the unit
   output logic      osc_running_o,
   output logic      pll_lock_o
);
   int lock_cnt = 0;

   // --------------------------------------------------------------
   // Oscillator and lock
   // --------------------------------------------------------------
   // The only reference is the on-chip oscillator, and it runs only while powered.
   assign osc_running_o = osc_en_i & ~lose_osc_i;
   // Lock needs a settling time, so a restarted PLL is never reported locked at once.
   always @(posedge core_clk_i) begin
      if (!pll_en_i || !osc_running_o || lose_lock_i) begin
         lock_cnt <= 0;
      end else if (lock_cnt < LOCK_CYC) begin
         lock_cnt <= lock_cnt + 1;
      end
   end
   assign pll_lock_o = (lock_cnt == LOCK_CYC);
endmodule : ccu_analog_model

// ===== dv/tb_ccu_clock_gen_unit.sv
// Self-checking testbench of the clock generation unit.
`timescale 1ns/10ps

module tb_ccu_clock_gen_unit;
   logic                    core_clk_i = 1'b0;
   logic                    rst_i      = 1'b1;
   ccu_pkg::ccu_apb_req_type req        = '0;
   logic [31:0]             prdata_o;
   logic                    pready_o, pslverr_o, osc_running_i, pll_lock_i;
   logic                    osc_en_o, pll_en_o, vco_range_sel_o, clock_out_pin_o;
   logic                    flash_prog_ok_o, irq_o;
   logic [3:0]              feedback_divider_sel_o;
   logic                    wake_i = 1'b0;
   logic                    lose_osc = 1'b0;
   logic                    lose_lock = 1'b0;
   ccu_pkg::ccu_clk_en_type clk_en_o;
   int                      mismatches = 0;
   int                      check_count = 0;
   logic [31:0]             c_ff, c_cpu, c_per, c_out, c_tmr, c_aux, rd;
   logic                    err;
   int                      mode_exp [4] = '{0, 2, 1, 2};
   int                      ff_exp [4] = '{48, 12, 3, 12};
   int                      ok_exp [4] = '{1, 0, 0, 0};

   always #25 core_clk_i = ~core_clk_i;

   ccu_clock_gen_unit dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .apb_req_i(req),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .osc_running_i(osc_running_i), .pll_lock_i(pll_lock_i), .osc_en_o(osc_en_o),
      .pll_en_o(pll_en_o), .vco_range_sel_o(vco_range_sel_o),
      .feedback_divider_sel_o(feedback_divider_sel_o), .wake_i(wake_i),
      .clk_en_o(clk_en_o), .clock_out_pin_o(clock_out_pin_o),
      .flash_prog_ok_o(flash_prog_ok_o), .irq_o(irq_o));

   ccu_analog_model model (.core_clk_i(core_clk_i), .osc_en_i(osc_en_o), .pll_en_i(pll_en_o),
      .lose_osc_i(lose_osc), .lose_lock_i(lose_lock), .osc_running_o(osc_running_i),
      .pll_lock_o(pll_lock_i));

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic results();
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Ready is registered, so right after a rising edge it still shows what that edge sampled.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge core_clk_i);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         mismatches++;
         results();
      end
      rd = prdata_o;
      err = pslverr_o;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, '0);
      chk(nm, exp, rd);
   endtask : rchk

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : settle

   task automatic count_win(input int n);
      logic prev;
      c_ff = '0;
      c_cpu = '0;
      c_per = '0;
      c_out = '0;
      c_tmr = '0;
      c_aux = '0;
      prev = clock_out_pin_o;
      repeat (n) begin
         @(posedge core_clk_i);
         c_ff = c_ff + 32'(clk_en_o.flash_fast);
         c_cpu = c_cpu + 32'(clk_en_o.cpu);
         c_per = c_per + 32'(clk_en_o.periph);
         c_tmr = c_tmr + 32'(clk_en_o.timer);
         c_aux = c_aux + 32'(clk_en_o.flash_aux);
         c_out = c_out + 32'(clock_out_pin_o & ~prev);
         prev = clock_out_pin_o;
      end
   endtask : count_win

   task automatic do_reset();
      rst_i <= 1'b1;
      settle(16);
      rst_i <= 1'b0;
      settle(20);
   endtask : do_reset

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      do_reset();
      rchk(ccu_pkg::CTRL_OFS, 32'h10, "ctrl_reset");
      rchk(ccu_pkg::PWR_OFS, 32'h0, "pwr_reset");
      chk("vco_range", 32'h0, 32'(vco_range_sel_o));
      chk("fb_sel", 32'h2, 32'(feedback_divider_sel_o));
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, ccu_pkg::CTRL_OFS, 32'h10 | 32'(i));
         apb(1'b0, ccu_pkg::INFO_OFS, '0);
         chk("mode", 32'(mode_exp[i]), {30'h0, rd[1:0]});
         settle(20);
         count_win(48);
         chk("sys_ticks", 32'(ff_exp[i]), c_ff);
         chk("flash_ok", 32'(ok_exp[i]), 32'(flash_prog_ok_o));
      end
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h10);
      settle(20);
      count_win(48);
      chk("cpu_ticks", 32'd16, c_cpu);
      chk("per_ticks", 32'd16, c_per);
      chk("tmr_ticks", 32'd16, c_tmr);
      chk("aux_ticks", 32'd48, c_aux);
      apb(1'b1, ccu_pkg::PWR_OFS, 32'h1);
      settle(10);
      count_win(48);
      chk("idle_cpu", 32'd0, c_cpu);
      chk("idle_per", 32'd16, c_per);
      wake_i <= 1'b1;
      settle(1);
      wake_i <= 1'b0;
      rchk(ccu_pkg::PWR_OFS, 32'h0, "pwr_wake");
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h410);
      apb(1'b1, ccu_pkg::PWR_OFS, 32'h2);
      settle(10);
      count_win(48);
      chk("slow_cpu", 32'd8, c_cpu);
      chk("slow_per", 32'd8, c_per);
      chk("slow_tmr", 32'd8, c_tmr);
      apb(1'b1, ccu_pkg::PWR_OFS, 32'h0);
      rchk(ccu_pkg::PWR_OFS, 32'h0, "pwr_slow_exit");
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h4012);
      settle(20);
      count_win(64);
      chk("clock_out_pin_pulse", 32'd4, c_out);
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h4092);
      settle(20);
      count_win(64);
      chk("clock_out_pin_toggle", 32'd2, c_out);
      apb(1'b1, ccu_pkg::CTRL_OFS, 32'h10);
      apb(1'b1, ccu_pkg::MASK_OFS, 32'h1);
      lose_lock <= 1'b1;
      settle(10);
      rchk(ccu_pkg::STAT_OFS, 32'h2, "stat_lock");
      chk("irq_masked", 32'h0, 32'(irq_o));
      lose_lock <= 1'b0;
      settle(20);
      apb(1'b1, ccu_pkg::STAT_OFS, 32'h2);
      rchk(ccu_pkg::STAT_OFS, 32'h0, "stat_w1c");
      lose_osc <= 1'b1;
      settle(10);
      rchk(ccu_pkg::STAT_OFS, 32'h3, "stat_osc");
      chk("irq_set", 32'h1, 32'(irq_o));
      lose_osc <= 1'b0;
      settle(20);
      apb(1'b1, ccu_pkg::STAT_OFS, 32'h3);
      settle(3);
      chk("irq_clear", 32'h0, 32'(irq_o));
      apb(1'b0, 8'h20, '0);
      chk("unmapped_err", 32'h1, 32'(err));
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, ccu_pkg::PWR_OFS, 32'h3);
      settle(3);
      chk("osc_off", 32'h0, 32'(osc_en_o));
      chk("pll_off", 32'h0, 32'(pll_en_o));
      count_win(48);
      chk("down_ticks", 32'd0, c_ff);
      do_reset();
      rchk(ccu_pkg::PWR_OFS, 32'h0, "pwr_after_reset");
      chk("osc_on", 32'h1, 32'(osc_en_o));
      results();
   end
endmodule : tb_ccu_clock_gen_unit

// ===== hdl/ccu_clock_gen_unit.sv
// Clock generation and power mode control with APB registers.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps

// Contract
// - Mode from osc_disconnect and vco_bypass: 00 PLL, 01 prescaler, 1x base.
// - Oscillator disconnected means base mode whatever vco_bypass holds.
// - Base mode system clock is free-running VCO divided by K.
// - Prescaler mode system clock is oscillator divided by P times K.
// - PLL mode system clock is oscillator times N over P times K.
// - P is fixed at 1 and K at 2, not programmable.
// - All clocks come from the system clock; CPU and peripherals at a third. Clock out pin select 3 takes the synchronised oscillator level instead.
// - Clock out pin carries a selected clock, halved by toggle latch when enabled.
// - Idle mode stops the CPU clock, other clocks keep running.
// - Slow-down divides CPU, timer and peripheral clocks by one common factor.
// - Power-down switches off oscillator and PLL.
// - Flash program and erase only at 80 MHz; reads at or below.
// - Reset enters active mode at main clock; software then picks power modes.
// - Detect oscillator stop and PLL loss of lock.
// - Reference is the on-chip 10 MHz oscillator only.
// - Normal running uses PLL mode.
module ccu_clock_gen_unit (
   // Clock and reset
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   // APB slave
   input  wire ccu_pkg::ccu_apb_req_type apb_req_i,
   output logic [31:0]                   prdata_o,
   output logic                          pready_o,
   output logic                          pslverr_o,
   // Analog oscillator and PLL
   input  wire logic                     osc_running_i,
   input  wire logic                     pll_lock_i,
   output logic                          osc_en_o,
   output logic                          pll_en_o,
   output logic                          vco_range_sel_o,
   output logic [3:0]                    feedback_divider_sel_o,
   // Wake-up from idle
   input  wire logic                     wake_i,
   // Clocks and status
   output ccu_pkg::ccu_clk_en_type       clk_en_o,
   output logic                          clock_out_pin_o,
   output logic                          flash_prog_ok_o,
   output logic                          irq_o
);

   typedef struct packed {
      ccu_pkg::ccu_ctrl_type   ctrl;
      ccu_pkg::ccu_mode_type   mode;
      ccu_pkg::ccu_pwr_type    pwr;
      logic [7:0]              period;
      logic [1:0]              status;
      logic [1:0]              mask;
      logic                    osc_s1;
      logic                    osc_s2;
      logic                    osc_q;
      logic                    lock_s1;
      logic                    lock_s2;
      logic                    lock_q;
      logic [1:0]              div3;
      logic [3:0]              slow_cnt;
      logic                    toggle;
      logic                    clock_out_pin;
      ccu_pkg::ccu_clk_en_type en;
      logic                    osc_en;
      logic                    pll_en;
      logic                    flash_ok;
      logic                    irq;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
   } ccu_state_type;

   ccu_state_type r;
   ccu_state_type r_nxt;
   logic          sys_tick;
   logic          acc;
   logic          wr;
   logic          base_tick;
   logic          slow_tick;
   logic          src;
   logic [1:0]    w1c;

   // ---------------------------------------------------------------
   // System tick divider
   // ---------------------------------------------------------------
   ccu_tick_div u_sys_div (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .run_i      (r.pwr != ccu_pkg::PWR_DOWN),
      .period_i   (r.period),
      .tick_o     (sys_tick)
   );

   assign acc = apb_req_i.psel && apb_req_i.penable;
   assign wr  = acc && r.pready && apb_req_i.pwrite;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      r_nxt     = r;
      base_tick = 1'b0;
      slow_tick = 1'b0;
      src       = 1'b0;
      w1c       = 2'b00;

      // Both status inputs come from the analog macro and are synchronised.
      r_nxt.osc_s1  = osc_running_i;
      r_nxt.osc_s2  = r.osc_s1;
      r_nxt.osc_q   = r.osc_s2;
      r_nxt.lock_s1 = pll_lock_i;
      r_nxt.lock_s2 = r.lock_s1;
      r_nxt.lock_q  = r.lock_s2;

      // Register writes.
      if (wr && apb_req_i.paddr == ccu_pkg::CTRL_OFS) begin
         r_nxt.ctrl = ccu_pkg::ccu_ctrl_type'(apb_req_i.pwdata[ccu_pkg::F_OEN:0]);
      end
      if (wr && apb_req_i.paddr == ccu_pkg::MASK_OFS) begin
         r_nxt.mask = apb_req_i.pwdata[ccu_pkg::N_STAT - 1:0];
      end
      if (wr && apb_req_i.paddr == ccu_pkg::STAT_OFS) begin
         w1c = apb_req_i.pwdata[ccu_pkg::N_STAT - 1:0];
      end

      r_nxt.mode   = ccu_pkg::ccu_mode(r_nxt.ctrl.osc_disconnect,
                                       r_nxt.ctrl.vco_bypass);
      // The reset control value selects PLL mode at N of 16.
      r_nxt.period = ccu_pkg::ccu_sys_period(r_nxt.mode,
                                             r_nxt.ctrl.feedback_divider_sel);

      // Power modes are entered only from active; idle leaves on a wake event.
      unique case (r.pwr)
         ccu_pkg::PWR_ACTIVE: begin
            if (wr && apb_req_i.paddr == ccu_pkg::PWR_OFS) begin
               r_nxt.pwr = ccu_pkg::ccu_pwr_type'(apb_req_i.pwdata[1:0]);
            end
         end
         ccu_pkg::PWR_IDLE: begin
            if (wake_i) begin
               r_nxt.pwr = ccu_pkg::PWR_ACTIVE;
            end
         end
         ccu_pkg::PWR_SLOW: begin
            if (wr && apb_req_i.paddr == ccu_pkg::PWR_OFS &&
                apb_req_i.pwdata[1:0] == 2'h0) begin
               r_nxt.pwr = ccu_pkg::PWR_ACTIVE;
            end
         end
         ccu_pkg::PWR_DOWN: begin
            // Only a reset leaves power-down, since the core has no clock to run on.
            r_nxt.pwr = ccu_pkg::PWR_DOWN;
         end
      endcase

      r_nxt.osc_en = (r_nxt.pwr != ccu_pkg::PWR_DOWN);
      r_nxt.pll_en = (r_nxt.pwr != ccu_pkg::PWR_DOWN);

      // Derived clock enables.
      if (sys_tick) begin
         r_nxt.div3 = (r.div3 == ccu_pkg::CPU_DIV_LAST) ? 2'h0 : r.div3 + 2'h1;
         base_tick  = (r.div3 == ccu_pkg::CPU_DIV_LAST);
      end
      if (base_tick) begin
         if (r.pwr != ccu_pkg::PWR_SLOW || r.slow_cnt >= r.ctrl.slowdown_divider) begin
            r_nxt.slow_cnt = 4'h0;
            slow_tick      = 1'b1;
         end else begin
            r_nxt.slow_cnt = r.slow_cnt + 4'h1;
         end
      end
      r_nxt.en.flash_fast = sys_tick;
      r_nxt.en.flash_aux  = sys_tick;
      r_nxt.en.periph     = slow_tick;
      r_nxt.en.timer      = slow_tick;
      r_nxt.en.cpu        = slow_tick && r.pwr != ccu_pkg::PWR_IDLE;

      // Clock output pin: the tick itself, or a toggle that halves it evenly.
      unique case (r.ctrl.clock_out_pin_sel)
         2'h0:    src = sys_tick;
         2'h1:    src = r_nxt.en.cpu;
         2'h2:    src = slow_tick;
         default: src = r.osc_s2;
      endcase
      if (src) begin
         r_nxt.toggle = !r.toggle;
      end
      r_nxt.clock_out_pin = r.ctrl.clock_out_pin_en &&
                     (r.ctrl.toggle_latch_en ? r_nxt.toggle : src);

      // Loss detection: a falling synchronised level sets a sticky flag,
      // and the set wins over a clear in the same cycle.
      r_nxt.status = r.status & ~w1c;
      if (r.osc_q && !r.osc_s2 && r.pwr != ccu_pkg::PWR_DOWN) begin
         r_nxt.status[ccu_pkg::S_OSC] = 1'b1;
      end
      if (r.lock_q && !r.lock_s2 && r.mode == ccu_pkg::MODE_PLL &&
          r.pwr != ccu_pkg::PWR_DOWN) begin
         r_nxt.status[ccu_pkg::S_LOCK] = 1'b1;
      end
      r_nxt.irq = |(r_nxt.status & r_nxt.mask);

      // Program and erase need the full 80 MHz PLL clock in lock.
      r_nxt.flash_ok = r_nxt.mode == ccu_pkg::MODE_PLL &&
                       r_nxt.ctrl.feedback_divider_sel == ccu_pkg::FEEDBACK_DIVIDER_SEL_80MHZ &&
                       !r_nxt.ctrl.vco_range_sel && r.lock_s2 &&
                       r_nxt.pwr != ccu_pkg::PWR_DOWN;

      // APB: one wait state, then ready with registered data.
      r_nxt.pready  = acc && !r.pready;
      r_nxt.pslverr = 1'b0;
      r_nxt.prdata  = 32'h0000_0000;
      if (acc && !r.pready) begin
         unique case (apb_req_i.paddr)
            ccu_pkg::CTRL_OFS: r_nxt.prdata = 32'(r.ctrl);
            ccu_pkg::PWR_OFS:  r_nxt.prdata = 32'(r.pwr);
            ccu_pkg::STAT_OFS: r_nxt.prdata = 32'(r.status);
            ccu_pkg::MASK_OFS: r_nxt.prdata = 32'(r.mask);
            ccu_pkg::INFO_OFS: r_nxt.prdata = 32'({r.flash_ok, r.osc_s2, r.lock_s2, r.mode});
            default:           r_nxt.pslverr = 1'b1;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r                           <= '0;
         r.ctrl.feedback_divider_sel <= ccu_pkg::FEEDBACK_DIVIDER_SEL_RST;
         r.mode                      <= ccu_pkg::MODE_PLL;
         r.pwr                       <= ccu_pkg::PWR_ACTIVE;
         r.period                    <= 8'h01;
         r.osc_en                    <= 1'b1;
         r.pll_en                    <= 1'b1;
      end else begin
         r <= r_nxt;
      end
   end

   assign prdata_o               = r.prdata;
   assign pready_o               = r.pready;
   assign pslverr_o              = r.pslverr;
   assign osc_en_o               = r.osc_en;
   assign pll_en_o               = r.pll_en;
   assign vco_range_sel_o        = r.ctrl.vco_range_sel;
   assign feedback_divider_sel_o = r.ctrl.feedback_divider_sel;
   assign clk_en_o               = r.en;
   assign clock_out_pin_o        = r.clock_out_pin;
   assign flash_prog_ok_o        = r.flash_ok;
   assign irq_o                  = r.irq;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_mode_base_sel: assert property (r.ctrl.osc_disconnect |-> r.mode == ccu_pkg::MODE_BASE)
      else $error("Disconnected oscillator not in base mode.");
   a_mode_pll_sel: assert property (!r.ctrl.osc_disconnect && !r.ctrl.vco_bypass
                                    |-> r.mode == ccu_pkg::MODE_PLL && r.period == 8'h01)
      else $error("PLL mode not selected at full rate.");
   a_prescale_period: assert property (r.mode == ccu_pkg::MODE_PRESCALE |-> r.period == 8'h10)
      else $error("Prescaler period wrong.");
   a_pdown_osc_off: assert property (r.pwr == ccu_pkg::PWR_DOWN |-> !osc_en_o && !pll_en_o)
      else $error("Oscillator or PLL on in power-down.");
   a_idle_cpu_gate: assert property (r.pwr == ccu_pkg::PWR_IDLE && $past(r.pwr) == ccu_pkg::PWR_IDLE
                                     |-> !clk_en_o.cpu)
      else $error("CPU clock runs in idle.");
   a_cpu_third_rate: assert property (clk_en_o.cpu && r.period == 8'h01 && r.pwr == ccu_pkg::PWR_ACTIVE
                                      |=> !clk_en_o.cpu [*2])
      else $error("CPU clock faster than a third of system.");
   a_reset_active: assert property ($past(rst_i) |-> r.pwr == ccu_pkg::PWR_ACTIVE)
      else $error("Not active after reset.");
   a_status_sticky: assert property ($past(r.status[ccu_pkg::S_OSC]) && !$past(w1c[ccu_pkg::S_OSC])
                                     |-> r.status[ccu_pkg::S_OSC])
      else $error("Oscillator loss flag lost.");
   a_irq_level: assert property (irq_o == |(r.status & r.mask))
      else $error("Interrupt does not follow masked status.");
   a_flash_80mhz: assert property (flash_prog_ok_o |-> r.mode == ccu_pkg::MODE_PLL &&
                                   r.ctrl.feedback_divider_sel == ccu_pkg::FEEDBACK_DIVIDER_SEL_80MHZ)
      else $error("Flash program allowed below 80 MHz.");
   a_apb_wait: assert property (acc && !pready_o |=> pready_o)
      else $error("APB ready late.");

endmodule : ccu_clock_gen_unit

// ===== hdl/ccu_pkg.sv
// Constants, types and helper functions of the clock control unit.
package ccu_pkg;

   // ---------------------------------------------------------------
   // Register map and field layout
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTRL_OFS      = 8'h00;
   localparam logic [7:0]  PWR_OFS       = 8'h04;
   localparam logic [7:0]  STAT_OFS      = 8'h08;
   localparam logic [7:0]  MASK_OFS      = 8'h0c;
   localparam logic [7:0]  INFO_OFS      = 8'h10;
   localparam int          F_DISC        = 0;
   localparam int          F_BYP         = 1;
   localparam int          F_VSEL        = 2;
   localparam int          F_FEEDBACK_DIVIDER_SEL        = 3;
   localparam int          F_TOGGLE_LATCH_EN        = 7;
   localparam int          F_OSEL        = 8;
   localparam int          F_SLOW        = 10;
   localparam int          F_OEN         = 14;
   localparam int          N_STAT        = 2;
   localparam int          S_OSC         = 0;
   localparam int          S_LOCK        = 1;
   localparam logic [3:0]  FEEDBACK_DIVIDER_SEL_RST      = 4'h2;
   localparam logic [3:0]  FEEDBACK_DIVIDER_SEL_80MHZ    = 4'h2;

   // ---------------------------------------------------------------
   // Clock figures in MHz and divider factors
   // ---------------------------------------------------------------
   localparam int          OSC_MHZ       = 10;
   localparam int          FSYS_MAX_MHZ  = 80;
   localparam int          VCO_BASE_MHZ  = 40;
   localparam int          P_FACTOR      = 1;
   localparam int          K_FACTOR      = 2;
   localparam int          CPU_DIV       = 3;
   localparam logic [1:0]  CPU_DIV_LAST  = 2'(CPU_DIV - 1);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {MODE_PLL, MODE_PRESCALE, MODE_BASE} ccu_mode_type;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_IDLE, PWR_SLOW, PWR_DOWN} ccu_pwr_type;

   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ccu_apb_req_type;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic timer;
      logic flash_fast;
      logic flash_aux;
   } ccu_clk_en_type;

   typedef struct packed {
      logic       clock_out_pin_en;
      logic [3:0] slowdown_divider;
      logic [1:0] clock_out_pin_sel;
      logic       toggle_latch_en;
      logic [3:0] feedback_divider_sel;
      logic       vco_range_sel;
      logic       vco_bypass;
      logic       osc_disconnect;
   } ccu_ctrl_type;

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------
   function automatic ccu_mode_type ccu_mode(input logic disc, input logic byp);
      if (disc) begin
         return MODE_BASE;
      end
      return byp ? MODE_PRESCALE : MODE_PLL;
   endfunction : ccu_mode

   function automatic int ccu_n_factor(input logic [3:0] sel);
      return 4 * int'(sel) + 8;
   endfunction : ccu_n_factor

   // Period of the system tick in core cycles, one core cycle standing for 80 MHz.
   function automatic logic [7:0] ccu_sys_period(input ccu_mode_type m, input logic [3:0] sel);
      int p;
      p = 1;
      unique case (m)
         MODE_PLL:      p = FSYS_MAX_MHZ * P_FACTOR * K_FACTOR / (OSC_MHZ * ccu_n_factor(sel));
         MODE_PRESCALE: p = FSYS_MAX_MHZ * P_FACTOR * K_FACTOR / OSC_MHZ;
         default:       p = FSYS_MAX_MHZ * K_FACTOR / VCO_BASE_MHZ;
      endcase
      return (p < 1) ? 8'h01 : 8'(p);
   endfunction : ccu_sys_period

endpackage : ccu_pkg

// ===== hdl/ccu_tick_div.sv
// Programmable divider that turns the core clock into a one-cycle tick.
`timescale 1ns/10ps

module ccu_tick_div (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       run_i,
   input  wire logic [7:0] period_i,
   // Tick
   output logic            tick_o
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } ccu_div_state_type;

   ccu_div_state_type r;
   ccu_div_state_type r_nxt;

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   // A changed period takes effect at once; a count already at or past the new end wraps in the next cycle.
   always_comb begin
      r_nxt      = r;
      r_nxt.tick = 1'b0;
      if (!run_i) begin
         r_nxt.cnt = 8'h00;
      end else if (r.cnt >= period_i - 8'h01) begin
         r_nxt.cnt  = 8'h00;
         r_nxt.tick = 1'b1;
      end else begin
         r_nxt.cnt = r.cnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign tick_o = r.tick;

endmodule : ccu_tick_div
